/* src/lsr_top.sv */
// What this block does
// R1: 16-bit live fault register at index 0x2F, resets to zero, fault bits unlatched.
// R2: Bit 14 sets each time a conversion cycle finishes.
// R3: Bit 14 stays set until software writes one to it.
// R4: Single mode: ready pin mirrors bit 14, deasserts only when it is cleared.
// R5: Continuous mode: ready pin returns high 24 us after asserting.
// R6: Bit 13 shows the converter busy, read only.
// R7: Bits 12 to 10 show channel A-D or diagnostic 0-3 being converted.
// R8: Bits 9 to 5 show 1.8 V, digital, analog, 5 V and pump faults live.
// R9: Bit 4 shows the over-temperature fault live.
// R10: Bits 3 to 0 show channel D, C, B, A faults live.
// R11: Output-function channel faults are debounced 2 ms before latching.
// R12: Writes to read-only bits do nothing; writing zero to bit 14 keeps it.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module lsr_top
    import lsr_pkg::*;
#(
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
)
(
    input wire logic MCLK, // System clock, 40 MHz.
    input wire logic RST, // Synchronous reset, active high.
    input wire logic CONV_DONE, // One-cycle pulse when a conversion ends.
    input wire logic CONV_BUSY, // Converter busy level.
    input wire logic [2:0] CONVERTING_SOURCE, // Source being converted.
    input wire logic REG_1V8_FAULT_LIVE, // 1.8 V regulator fault.
    input wire logic DIGITAL_SUPPLY_FAULT_LIVE, // Digital supply fault.
    input wire logic ANALOG_SUPPLY_FAULT_LIVE, // Analog supply fault.
    input wire logic REG_5V_FAULT_LIVE, // 5 V regulator fault.
    input wire logic CHARGE_PUMP_FAULT_LIVE, // Charge pump fault.
    input wire logic OVERHEAT_LIVE, // Die at or above about 115 C.
    input wire logic [3:0] CHAN_FAULT_RAW, // Raw channel faults, bit 0 is A.
    input wire logic [3:0] CHAN_OUTPUT_FUNC, // Channel in an output function.
    output logic CONV_READY_N, // Conversion ready pin, active low.
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // Write address.
    input wire logic S_AXI_AWVALID, // Write address valid.
    output logic S_AXI_AWREADY, // Write address ready.
    input wire logic [31:0] S_AXI_WDATA, // Write data.
    input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes.
    input wire logic S_AXI_WVALID, // Write data valid.
    output logic S_AXI_WREADY, // Write data ready.
    output logic [1:0] S_AXI_BRESP, // Write response.
    output logic S_AXI_BVALID, // Write response valid.
    input wire logic S_AXI_BREADY, // Write response ready.
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // Read address.
    input wire logic S_AXI_ARVALID, // Read address valid.
    output logic S_AXI_ARREADY, // Read address ready.
    output logic [31:0] S_AXI_RDATA, // Read data.
    output logic [1:0] S_AXI_RRESP, // Read response.
    output logic S_AXI_RVALID, // Read data valid.
    input wire logic S_AXI_RREADY // Read data ready.
);
    localparam int PULSE_W = $clog2(READY_PULSE_CYCLES + 1);

    // Matches a byte address against a register index.
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] index);
        addr_hit = (addr[ADDR_W-1:2] == index[ADDR_W-3:0]);
    endfunction : addr_hit

    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_held_reg, w_held_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic done_flag_reg, done_flag_next;
    logic [15:0] live_reg;
    logic [3:0] latch_reg;
    logic cont_mode_reg;
    logic ready_n_reg;
    logic [PULSE_W-1:0] pulse_cnt_reg;
    lsr_pin_state_type pin_state_reg;
    logic [3:0] chan_fault;
    logic aw_take, w_take, wr_do, ar_take;
    logic wr_live, wr_latch, wr_ctrl;
    logic done_clear;
    logic [3:0] latch_clear;

    assign aw_take = S_AXI_AWVALID && awready_reg;
    assign w_take = S_AXI_WVALID && wready_reg;
    assign wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
    assign ar_take = S_AXI_ARVALID && arready_reg;
    assign wr_live = wr_do && addr_hit(waddr_reg, LIVE_INDEX);
    assign wr_latch = wr_do && addr_hit(waddr_reg, LATCH_INDEX);
    assign wr_ctrl = wr_do && addr_hit(waddr_reg, CTRL_INDEX);

    // R11: debounce channel faults
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_chan
            lsr_debounce #(.CYCLES(DEBOUNCE_LEN)) u_deb (
                .clk(MCLK),
                .rst(RST),
                .raw(CHAN_FAULT_RAW[ch]),
                .enable(CHAN_OUTPUT_FUNC[ch]),
                .fault_reg(chan_fault[ch])
            );
        end
    endgenerate

    // Write address and data are taken in either order and held until used.
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_reg <= 1'b1;
                waddr_reg <= S_AXI_AWADDR;
                awready_reg <= 1'b0;
            end
            else if (wr_do)
            begin
                aw_held_reg <= 1'b0;
            end
            else if (!aw_held_reg && !bvalid_reg)
            begin
                awready_reg <= 1'b1;
            end
            if (w_take)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
                wready_reg <= 1'b0;
            end
            else if (wr_do)
            begin
                w_held_reg <= 1'b0;
            end
            else if (!w_held_reg && !bvalid_reg)
            begin
                wready_reg <= 1'b1;
            end
        end
    end

    // Write response follows the write; unmapped addresses answer SLVERR.
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end
        else if (wr_do)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_live || wr_latch || wr_ctrl) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_BREADY && bvalid_reg)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read channel: one read under way, data comes from a register.
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            if (addr_hit(S_AXI_ARADDR, LIVE_INDEX))
                rdata_reg <= {16'h0000, live_reg};
            else if (addr_hit(S_AXI_ARADDR, LATCH_INDEX))
                rdata_reg <= {28'h000_0000, latch_reg};
            else if (addr_hit(S_AXI_ARADDR, CTRL_INDEX))
                rdata_reg <= {31'h0000_0000, cont_mode_reg};
            else
            begin
                rdata_reg <= '0;
                rresp_reg <= RESP_SLVERR;
            end
        end
        else if (S_AXI_RREADY && rvalid_reg)
        begin
            rvalid_reg <= 1'b0;
        end
        else if (!rvalid_reg)
        begin
            arready_reg <= 1'b1;
        end
    end

    // R3: write one clears flag
    assign done_clear = wr_live && wstrb_reg[1] && wdata_reg[DONE_BIT];
    // R2: completion sets flag, set wins over clear
    assign done_flag_next = CONV_DONE || (done_flag_reg && !done_clear);

    always_ff @(posedge MCLK)
    begin
        if (RST)
            done_flag_reg <= LIVE_RESET[DONE_BIT];
        else
            done_flag_reg <= done_flag_next;
    end

    // R1: live snapshot, unlatched faults
    // R12: read-only bits ignore writes
    always_ff @(posedge MCLK)
    begin
        if (RST)
            live_reg <= LIVE_RESET;
        else
        begin
            live_reg <= LIVE_RESET;
            live_reg[DONE_BIT] <= done_flag_next;
            // R6: busy indication
            live_reg[BUSY_BIT] <= CONV_BUSY;
            // R7: converting source code
            live_reg[SRC_LSB+:3] <= CONVERTING_SOURCE;
            // R8: supply faults live
            live_reg[REG_1V8_BIT] <= REG_1V8_FAULT_LIVE;
            live_reg[DIG_SUPPLY_BIT] <= DIGITAL_SUPPLY_FAULT_LIVE;
            live_reg[ANA_SUPPLY_BIT] <= ANALOG_SUPPLY_FAULT_LIVE;
            live_reg[REG_5V_BIT] <= REG_5V_FAULT_LIVE;
            live_reg[PUMP_BIT] <= CHARGE_PUMP_FAULT_LIVE;
            // R9: over-temperature live
            live_reg[OVERHEAT_BIT] <= OVERHEAT_LIVE;
            // R10: channel faults live
            live_reg[CHAN_LSB+:4] <= chan_fault;
        end
    end

    // R11: latch qualified channel faults
    assign latch_clear = (wr_latch && wstrb_reg[0]) ? wdata_reg[3:0] : 4'h0;

    always_ff @(posedge MCLK)
    begin
        if (RST)
            latch_reg <= LATCH_RESET;
        else
            latch_reg <= chan_fault | (latch_reg & ~latch_clear);
    end

    // Conversion mode control: zero is single, one is continuous.
    always_ff @(posedge MCLK)
    begin
        if (RST)
            cont_mode_reg <= CTRL_RESET;
        else if (wr_ctrl && wstrb_reg[0])
            cont_mode_reg <= wdata_reg[CONT_MODE_BIT];
    end

    // Ready pin: mirrors the flag in single mode, timed pulse in continuous mode.
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            ready_n_reg <= 1'b1;
            pulse_cnt_reg <= '0;
            pin_state_reg <= PIN_IDLE;
        end
        else if (!cont_mode_reg)
        begin
            // R4: pin mirrors flag
            ready_n_reg <= !done_flag_next;
            pin_state_reg <= PIN_IDLE;
            pulse_cnt_reg <= '0;
        end
        else if (CONV_DONE)
        begin
            ready_n_reg <= 1'b0;
            pin_state_reg <= PIN_TIMING;
            pulse_cnt_reg <= PULSE_W'(READY_PULSE_CYCLES - 1);
        end
        else
        begin
            case (pin_state_reg)
                PIN_TIMING:
                begin
                    // R5: release after 24 us
                    if (pulse_cnt_reg == '0)
                    begin
                        ready_n_reg <= 1'b1;
                        pin_state_reg <= PIN_IDLE;
                    end
                    else
                        pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
                end
                PIN_IDLE:
                    ready_n_reg <= 1'b1;
                default:
                    pin_state_reg <= PIN_IDLE;
            endcase
        end
    end

    assign CONV_READY_N = ready_n_reg;
    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;
endmodule : lsr_top
`default_nettype wire

/* src/lsr_pkg.sv */
// Shared constants for the live status register block.
package lsr_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] LIVE_INDEX = 8'h2F;
    localparam logic [7:0] LATCH_INDEX = 8'h30;
    localparam logic [7:0] CTRL_INDEX = 8'h31;
    localparam int ADDR_W = 8;
    // Field positions of the live fault snapshot and of the mode control bit.
    localparam int DONE_BIT = 14;
    localparam int BUSY_BIT = 13;
    localparam int SRC_LSB = 10;
    localparam int REG_1V8_BIT = 9;
    localparam int DIG_SUPPLY_BIT = 8;
    localparam int ANA_SUPPLY_BIT = 7;
    localparam int REG_5V_BIT = 6;
    localparam int PUMP_BIT = 5;
    localparam int OVERHEAT_BIT = 4;
    localparam int CHAN_LSB = 0;
    localparam int CONT_MODE_BIT = 0;
    // Reset values.
    localparam logic [15:0] LIVE_RESET = 16'h0000;
    localparam logic [3:0] LATCH_RESET = 4'h0;
    localparam logic CTRL_RESET = 1'b0;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Timing: clock period, ready pulse length and channel fault debounce.
    localparam int CLK_PERIOD_PS = 25000;
    localparam int READY_PULSE_NS = 24000;
    localparam int READY_PULSE_CYCLES = (READY_PULSE_NS * 1000) / CLK_PERIOD_PS;
    localparam int DEBOUNCE_US = 2000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_US * 1000) / (CLK_PERIOD_PS / 1000);
    // Source codes of the converting source field.
    typedef enum logic [2:0] {
        SRC_CHAN_A = 3'b000,
        SRC_CHAN_B = 3'b001,
        SRC_CHAN_C = 3'b010,
        SRC_CHAN_D = 3'b011,
        SRC_DIAG_0 = 3'b100,
        SRC_DIAG_1 = 3'b101,
        SRC_DIAG_2 = 3'b110,
        SRC_DIAG_3 = 3'b111
    } lsr_source_type;
    // Mode of the continuous ready pin timer.
    typedef enum logic [0:0] {
        PIN_IDLE = 1'b0,
        PIN_TIMING = 1'b1
    } lsr_pin_state_type;
endpackage : lsr_pkg

/* src/lsr_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
// Qualifies one channel fault: a rising fault must hold for the debounce time.
module lsr_debounce
    import lsr_pkg::*;
#(
    parameter int CYCLES = DEBOUNCE_CYCLES
)
(
    input wire logic clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic raw, // Raw fault condition.
    input wire logic enable, // Debounce on when the channel drives an output.
    output logic fault_reg // Qualified fault.
);
    localparam int CNT_W = $clog2(CYCLES + 1);
    logic [CNT_W-1:0] count_reg;

    // Count while the raw fault stands; a clearing fault passes at once.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_reg <= '0;
            fault_reg <= 1'b0;
        end
        else if (!raw)
        begin
            count_reg <= '0;
            fault_reg <= 1'b0;
        end
        else if (!enable)
        begin
            fault_reg <= 1'b1;
        end
        else if (count_reg >= CNT_W'(CYCLES - 1))
        begin
            fault_reg <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 1'b1;
        end
    end
endmodule : lsr_debounce
`default_nettype wire

/* tb/lsr_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Checks bus timing and the ready pin of the live status block.
module lsr_sva
    import lsr_pkg::*;
#(
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
)
(
    input wire logic MCLK, // Clock.
    input wire logic RST, // Reset.
    input wire logic CONV_DONE, // Done pulse.
    input wire logic CONV_READY_N, // Ready pin.
    input wire logic S_AXI_AWVALID, // Bus.
    input wire logic S_AXI_AWREADY, // Bus.
    input wire logic S_AXI_WVALID, // Bus.
    input wire logic S_AXI_WREADY, // Bus.
    input wire logic S_AXI_BVALID, // Bus.
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // Bus.
    input wire logic S_AXI_ARVALID, // Bus.
    input wire logic S_AXI_ARREADY, // Bus.
    input wire logic [31:0] S_AXI_RDATA, // Bus.
    input wire logic [1:0] S_AXI_RRESP, // Bus.
    input wire logic S_AXI_RVALID // Bus.
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    reset_idle_a: assert property ($fell(RST) |-> CONV_READY_N
        && !S_AXI_BVALID && !S_AXI_RVALID) else $error("Outputs not idle after reset.");
    done_pin_a: assert property (CONV_DONE |=> !CONV_READY_N)
        else $error("Ready pin missed a conversion.");
    pin_cause_a: assert property ($fell(CONV_READY_N) |-> $past(CONV_DONE))
        else $error("Ready pin fell without a conversion.");
    upper_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:15] == 17'h0_0000)
        else $error("Reserved read bits not zero.");
    read_lat_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("Read answer late.");
    write_lat_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("Write answer late.");
    write_busy_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("Write accepted during response.");
    read_busy_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("Read accepted during response.");
    unmapped_err_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        && !(S_AXI_ARADDR inside {8'hBC, 8'hC0, 8'hC4})
        |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
        else $error("Unmapped read not refused.");
endmodule : lsr_sva
// Attaches the checker to every live status block.
bind lsr_top lsr_sva #(.DEBOUNCE_LEN(DEBOUNCE_LEN)) i_sva (
    .MCLK(MCLK), .RST(RST), .CONV_DONE(CONV_DONE), .CONV_READY_N(CONV_READY_N),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID)
);
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Drives the live status block through its register bus and condition inputs.
module tb_top
    import lsr_pkg::*;
    ;
    localparam int DB = 8;
    logic MCLK = 1'b0, RST = 1'b1, CONV_DONE = 1'b0, CONV_BUSY = 1'b0;
    logic REG_1V8_FAULT_LIVE = 1'b0, DIGITAL_SUPPLY_FAULT_LIVE = 1'b0;
    logic ANALOG_SUPPLY_FAULT_LIVE = 1'b0, REG_5V_FAULT_LIVE = 1'b0;
    logic CHARGE_PUMP_FAULT_LIVE = 1'b0, OVERHEAT_LIVE = 1'b0, CONV_READY_N;
    logic [2:0] CONVERTING_SOURCE = 3'h0;
    logic [3:0] CHAN_FAULT_RAW = 4'h0, CHAN_OUTPUT_FUNC = 4'h0, S_AXI_WSTRB = 4'h0, ch;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [5:0] f6;
    int miscompares = 0;
    int n_tests = 0;
    int n;

    // The debounce runs with a short count so the run stays brief.
    lsr_top #(
        .DEBOUNCE_LEN(DB)
    ) i_dut (
        .MCLK(MCLK), .RST(RST), .CONV_DONE(CONV_DONE), .CONV_BUSY(CONV_BUSY),
        .CONVERTING_SOURCE(CONVERTING_SOURCE), .REG_1V8_FAULT_LIVE(REG_1V8_FAULT_LIVE),
        .DIGITAL_SUPPLY_FAULT_LIVE(DIGITAL_SUPPLY_FAULT_LIVE),
        .ANALOG_SUPPLY_FAULT_LIVE(ANALOG_SUPPLY_FAULT_LIVE),
        .REG_5V_FAULT_LIVE(REG_5V_FAULT_LIVE), .CHARGE_PUMP_FAULT_LIVE(CHARGE_PUMP_FAULT_LIVE),
        .OVERHEAT_LIVE(OVERHEAT_LIVE), .CHAN_FAULT_RAW(CHAN_FAULT_RAW),
        .CHAN_OUTPUT_FUNC(CHAN_OUTPUT_FUNC), .CONV_READY_N(CONV_READY_N),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
        .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
        .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
        .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
        .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
        .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
        .S_AXI_RREADY(S_AXI_RREADY)
    );

    // Compares one observed value with its expectation.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Offers address and data together, releases each when taken, then takes the answer.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do
        begin
            @(posedge MCLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY)
                S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY)
                S_AXI_WVALID <= 1'b0;
        end
        while ((S_AXI_AWVALID && !S_AXI_AWREADY) || (S_AXI_WVALID && !S_AXI_WREADY));
        do
            @(posedge MCLK);
        while (!S_AXI_BVALID);
        S_AXI_BREADY <= 1'b0;
        chk(32'(S_AXI_BRESP), 32'(er));
    endtask : wr

    // Reads one word and compares data and response.
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do
            @(posedge MCLK);
        while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 1'b0;
        do
            @(posedge MCLK);
        while (!S_AXI_RVALID);
        S_AXI_RREADY <= 1'b0;
        chk(S_AXI_RDATA, e);
        chk(32'(S_AXI_RRESP), 32'(er));
    endtask : rd

    // Gives a one-cycle conversion done pulse.
    task automatic pulse_done();
        CONV_DONE <= 1'b1;
        @(posedge MCLK);
        CONV_DONE <= 1'b0;
    endtask : pulse_done

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // Clock of 25 ns.
    initial
    begin
        forever #12.5 MCLK = ~MCLK;
    end

    // Cuts a hang short well after the tests should have ended.
    initial
    begin
        repeat (10000) @(posedge MCLK);
        miscompares++;
        end_sim();
    end

    // Main sequence of bus calls and condition changes.
    initial
    begin
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        chk(32'(CONV_READY_N), 32'h1);
        rd(8'hBC, 32'h0000_0000, RESP_OKAY);
        rd(8'hC4, 32'h0000_0000, RESP_OKAY);
        for (int i = 0; i < 8; i++)
        begin
            f6 = 6'h15 ^ 6'(i * 7);
            ch = 4'(i * 5);
            CONV_BUSY <= i[0];
            CONVERTING_SOURCE <= 3'(i);
            {REG_1V8_FAULT_LIVE, DIGITAL_SUPPLY_FAULT_LIVE, ANALOG_SUPPLY_FAULT_LIVE,
             REG_5V_FAULT_LIVE, CHARGE_PUMP_FAULT_LIVE, OVERHEAT_LIVE} <= f6;
            CHAN_FAULT_RAW <= ch;
            repeat (3) @(posedge MCLK);
            rd(8'hBC, {18'h0, i[0], 3'(i), f6, ch}, RESP_OKAY);
            wr(8'hBC, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
            rd(8'hBC, {18'h0, i[0], 3'(i), f6, ch}, RESP_OKAY);
        end
        {CONV_BUSY, CONVERTING_SOURCE, REG_1V8_FAULT_LIVE, DIGITAL_SUPPLY_FAULT_LIVE,
         ANALOG_SUPPLY_FAULT_LIVE, REG_5V_FAULT_LIVE, CHARGE_PUMP_FAULT_LIVE, OVERHEAT_LIVE,
         CHAN_FAULT_RAW} <= 14'h0000;
        repeat (3) @(posedge MCLK);
        rd(8'hBC, 32'h0000_0000, RESP_OKAY);
        // Faults seen without an output function were latched at once; clear them.
        rd(8'hC0, 32'h0000_000F, RESP_OKAY);
        wr(8'hC0, 32'h0000_000F, 4'h1, RESP_OKAY);
        rd(8'hC0, 32'h0000_0000, RESP_OKAY);
        pulse_done();
        repeat (2) @(posedge MCLK);
        chk(32'(CONV_READY_N), 32'h0);
        rd(8'hBC, 32'h0000_4000, RESP_OKAY);
        wr(8'hBC, 32'h0000_0000, 4'hF, RESP_OKAY);
        rd(8'hBC, 32'h0000_4000, RESP_OKAY);
        chk(32'(CONV_READY_N), 32'h0);
        wr(8'hBC, 32'h0000_4000, 4'h3, RESP_OKAY);
        rd(8'hBC, 32'h0000_0000, RESP_OKAY);
        chk(32'(CONV_READY_N), 32'h1);
        // Continuous mode: the pin pulse length is counted while the flag stays set.
        wr(8'hC4, 32'h0000_0001, 4'h1, RESP_OKAY);
        rd(8'hC4, 32'h0000_0001, RESP_OKAY);
        pulse_done();
        n = 0;
        while (CONV_READY_N !== 1'b0)
            @(posedge MCLK);
        while (CONV_READY_N === 1'b0)
        begin
            @(posedge MCLK);
            n++;
        end
        chk(32'(n), 32'(READY_PULSE_CYCLES));
        rd(8'hBC, 32'h0000_4000, RESP_OKAY);
        wr(8'hBC, 32'h0000_4000, 4'h3, RESP_OKAY);
        wr(8'hC4, 32'h0000_0000, 4'h1, RESP_OKAY);
        // A short channel fault is filtered, a long one is latched.
        CHAN_OUTPUT_FUNC <= 4'h1;
        CHAN_FAULT_RAW <= 4'h1;
        repeat (DB / 2) @(posedge MCLK);
        CHAN_FAULT_RAW <= 4'h0;
        repeat (3) @(posedge MCLK);
        rd(8'hC0, 32'h0000_0000, RESP_OKAY);
        CHAN_FAULT_RAW <= 4'h1;
        repeat (DB + 3) @(posedge MCLK);
        rd(8'hBC, 32'h0000_0001, RESP_OKAY);
        rd(8'hC0, 32'h0000_0001, RESP_OKAY);
        CHAN_FAULT_RAW <= 4'h0;
        repeat (3) @(posedge MCLK);
        rd(8'hBC, 32'h0000_0000, RESP_OKAY);
        wr(8'hC0, 32'h0000_0001, 4'h1, RESP_OKAY);
        rd(8'hC0, 32'h0000_0000, RESP_OKAY);
        wr(8'h80, 32'h0000_0001, 4'hF, RESP_SLVERR);
        rd(8'h80, 32'h0000_0000, RESP_SLVERR);
        // A reset in mid-run drops a set flag and raises the ready pin.
        pulse_done();
        RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        chk(32'(CONV_READY_N), 32'h1);
        rd(8'hBC, 32'h0000_0000, RESP_OKAY);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
